// File: verilog/pss_pkg.sv
// Purpose: Shared constants and types of the position selector switch
// Assumes: 100 MHz pclk, APB register access
// Notes: Times are held in their own unit and turned into counts here
`default_nettype none
package pss_pkg;
  // Clock and tick timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned ALARM_MS = 3000;
  localparam logic [4:0] ALARM_TICKS = 5'(ALARM_MS / TICK_MS);
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_TIMEOUT = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  // Control register fields
  localparam int CTRL_LIMIT_LSB = 0;
  localparam int CTRL_INC_MODE = 3;
  localparam int CTRL_CODE_MODE = 4;
  // Status register fields
  localparam int STAT_POS_LSB = 0;
  localparam int STAT_PRE_LSB = 3;
  localparam int STAT_INC_BUSY = 6;
  localparam int STAT_CODE_BUSY = 7;
  localparam int STAT_SEL_ALARM = 8;
  localparam int STAT_INC_ALARM = 9;
  localparam int STAT_CODE_ALARM = 10;
  localparam int STAT_PWR_ALARM = 11;
  // Reset values and limits, time-out in 100 ms units
  localparam logic [2:0] LIMIT_RST = 3'h7;
  localparam logic [2:0] LIMIT_MIN = 3'h1;
  localparam logic [9:0] TIMEOUT_RST = 10'h032;
  localparam logic [9:0] TIMEOUT_MIN = 10'h01E;
  localparam logic [9:0] TIMEOUT_MAX = 10'h258;
  // Power-up modes
  localparam logic [1:0] PWR_RESTORE = 2'h0;
  localparam logic [1:0] PWR_SYNC = 2'h1;
  localparam logic [1:0] PWR_SYNC_RESTORE = 2'h2;
  // Sequence states
  typedef enum logic [2:0] {
    PSS_IDLE = 3'b001,
    PSS_INC = 3'b010,
    PSS_CODE = 3'b100
  } pss_state_t;

  // Next position when stepping, wrapping after the upper limit
  function automatic logic [2:0] pss_step(input logic [2:0] pos, input logic [2:0] limit);
    pss_step = (pos >= limit) ? 3'h1 : 3'(pos + 3'h1);
  endfunction : pss_step

  // Position lies between 1 and the upper limit
  function automatic logic pss_in_range(input logic [2:0] pos, input logic [2:0] limit);
    pss_in_range = (pos != 3'h0) && (pos <= limit);
  endfunction : pss_in_range
endpackage : pss_pkg
`default_nettype wire

// File: verilog/pss_tick.sv
// Purpose: Divider giving a one-cycle enable every tick period
// Assumes: Single clock domain
// Notes: Period is a parameter so simulation can shorten it
`default_nettype none
module pss_tick #(
  parameter int unsigned CYCLES = pss_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tick enable
  output logic tick
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_tick;

  if (CYCLES < 2) begin : g_chk
    $error("pss_tick: CYCLES must be at least 2");
  end

  always_comb begin
    next_tick = (count == 32'(CYCLES - 1));
    next_count = next_tick ? 32'h0000_0000 : 32'(count + 32'h0000_0001);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule : pss_tick
`default_nettype wire

// File: verilog/pss_top.sv
// Purpose: Digital multi-position selector switch with step and code paths
// Assumes: 100 MHz pclk, control pins asynchronous, APB slave with no wait states
// Notes: Timing resolution is one 100 ms tick
// Operation
// - Upper limit 1..7, position 1 lowest
// - Out-of-range code refused, selector alarm 3 s
// - Time-out 3.0 to 60.0 s, 0.1 s steps
// - Step time-out mode applies after inactivity
// - Confirm mode: activity restarts timer, expiry alarms
// - Step edge advances, wraps to 1
// - Step edge restarts timer, signals change initiated
// - Step confirm missed: step alarm 3 s
// - Step confirm edge applies, confirm mode only
// - Code bits unsigned, bit 2 most significant
// - Code zero is rest, no action
// - Code applies after time-out or confirm edge
// - Step and code paths lock each other out
// - Code confirm missed: code alarm 3 s
// - Separate confirm inputs per path
// - Position kept in storage, restored or synced
// - Power-up sync applies code at once, else 0
// - Restored position out of range gives 0, alarm
`default_nettype none
module pss_top #(
  parameter int unsigned TICK_CYCLES = pss_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pins
  input wire logic increment_in,
  input wire logic increment_confirm,
  input wire logic code_bit0,
  input wire logic code_bit1,
  input wire logic code_bit2,
  input wire logic code_confirm,
  input wire logic [1:0] powerup_mode,
  // Non-volatile position storage
  input wire logic [2:0] nv_position,
  output logic nv_write,
  output logic [2:0] nv_data,
  // Selector outputs
  output logic [2:0] position,
  output logic [2:0] preselect,
  output logic change_initiated,
  output logic selector_alarm,
  output logic increment_confirm_alarm,
  output logic code_confirm_alarm,
  output logic startup_alarm
);
  localparam int SW = 11;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("pss_top: TICK_CYCLES must be at least 2");
  end

  logic tick;

  pss_tick #(.CYCLES(TICK_CYCLES)) i_pss_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // Pin synchronisers; the first stage feeds only the second
  logic [SW-1:0] pin_meta, pin_sync, pin_prev, pin_raw;
  assign pin_raw = {powerup_mode, nv_position, code_confirm, code_bit2, code_bit1, code_bit0,
                    increment_confirm, increment_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic inc_rise, inc_ack_rise, code_ack_rise, code_moved;
  logic [2:0] code_now, nv_now;
  logic [1:0] pwr_now;
  assign inc_rise = pin_sync[0] & ~pin_prev[0];
  assign inc_ack_rise = pin_sync[1] & ~pin_prev[1];
  assign code_ack_rise = pin_sync[5] & ~pin_prev[5];
  assign code_now = pin_sync[4:2];
  assign code_moved = (pin_sync[4:2] != pin_prev[4:2]);
  assign nv_now = pin_sync[8:6];
  assign pwr_now = pin_sync[10:9];

  // Configuration registers
  logic [2:0] limit;
  logic inc_confirm_mode, code_confirm_mode;
  logic [9:0] timeout;
  // Selector state
  pss_pkg::pss_state_t state, next_state;
  logic [9:0] timer, next_timer;
  logic [4:0] cnt_sel, cnt_inc, cnt_code, cnt_pwr;
  logic [4:0] next_cnt_sel, next_cnt_inc, next_cnt_code, next_cnt_pwr;
  logic [1:0] boot, next_boot;
  logic [2:0] next_position, next_preselect;
  logic next_init, next_nv_write, timer_done;

  // Counts down one tick per tick while nonzero
  function automatic logic [4:0] pss_decay(input logic [4:0] c, input logic t);
    pss_decay = (t && c != 5'h00) ? 5'(c - 5'h01) : c;
  endfunction : pss_decay

  assign timer_done = tick && (10'(timer + 10'h001) >= timeout);

  always_comb begin
    next_state = state;
    next_timer = tick ? 10'(timer + 10'h001) : timer;
    next_position = position;
    next_preselect = preselect;
    next_init = 1'b0;
    next_nv_write = 1'b0;
    next_boot = boot;
    next_cnt_sel = pss_decay(cnt_sel, tick);
    next_cnt_inc = pss_decay(cnt_inc, tick);
    next_cnt_code = pss_decay(cnt_code, tick);
    next_cnt_pwr = pss_decay(cnt_pwr, tick);
    if (boot != 2'h3) begin
      // Wait for the synchronisers to fill before the power-up decision
      next_boot = 2'(boot + 2'h1);
      next_state = pss_pkg::PSS_IDLE;
      if (boot == 2'h2) begin
        if ((pwr_now != pss_pkg::PWR_RESTORE) && pss_pkg::pss_in_range(code_now, limit)) begin
          next_position = code_now;
        end else if ((pwr_now != pss_pkg::PWR_SYNC) && pss_pkg::pss_in_range(nv_now, limit)) begin
          next_position = nv_now;
        end else begin
          next_position = 3'h0;
          next_cnt_pwr = pss_pkg::ALARM_TICKS;
        end
        next_preselect = next_position;
      end
    end else begin
      unique case (state)
        pss_pkg::PSS_IDLE: begin
          if (inc_rise) begin
            next_preselect = pss_pkg::pss_step(position, limit);
            next_timer = 10'h000;
            next_init = 1'b1;
            next_state = pss_pkg::PSS_INC;
          end else if (code_moved && code_now != 3'h0) begin
            if (pss_pkg::pss_in_range(code_now, limit)) begin
              next_preselect = code_now;
              next_timer = 10'h000;
              next_state = pss_pkg::PSS_CODE;
            end else begin
              next_cnt_sel = pss_pkg::ALARM_TICKS;
            end
          end
        end
        pss_pkg::PSS_INC: begin
          // Code pins are ignored for the whole step sequence
          if (inc_rise) begin
            next_preselect = pss_pkg::pss_step(preselect, limit);
            next_timer = 10'h000;
            next_init = 1'b1;
          end else if (inc_confirm_mode && inc_ack_rise) begin
            next_position = preselect;
            next_nv_write = 1'b1;
            next_state = pss_pkg::PSS_IDLE;
          end else if (timer_done) begin
            if (inc_confirm_mode) begin
              next_preselect = position;
              next_cnt_inc = pss_pkg::ALARM_TICKS;
            end else begin
              next_position = preselect;
              next_nv_write = 1'b1;
            end
            next_state = pss_pkg::PSS_IDLE;
          end
        end
        pss_pkg::PSS_CODE: begin
          // Step pin is ignored for the whole code sequence
          if (code_moved && code_now != 3'h0) begin
            next_timer = 10'h000;
            if (pss_pkg::pss_in_range(code_now, limit)) begin
              next_preselect = code_now;
            end else begin
              next_cnt_sel = pss_pkg::ALARM_TICKS;
            end
          end else if (code_confirm_mode && code_ack_rise) begin
            next_position = preselect;
            next_nv_write = 1'b1;
            next_state = pss_pkg::PSS_IDLE;
          end else if (timer_done) begin
            if (code_confirm_mode) begin
              next_preselect = position;
              next_cnt_code = pss_pkg::ALARM_TICKS;
            end else begin
              next_position = preselect;
              next_nv_write = 1'b1;
            end
            next_state = pss_pkg::PSS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pss_pkg::PSS_IDLE;
      timer <= 10'h000;
      position <= 3'h0;
      preselect <= 3'h0;
      change_initiated <= 1'b0;
      nv_write <= 1'b0;
      nv_data <= 3'h0;
      boot <= 2'h0;
      cnt_sel <= 5'h00;
      cnt_inc <= 5'h00;
      cnt_code <= 5'h00;
      cnt_pwr <= 5'h00;
      selector_alarm <= 1'b0;
      increment_confirm_alarm <= 1'b0;
      code_confirm_alarm <= 1'b0;
      startup_alarm <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      position <= next_position;
      preselect <= next_preselect;
      change_initiated <= next_init;
      nv_write <= next_nv_write;
      nv_data <= next_position;
      boot <= next_boot;
      cnt_sel <= next_cnt_sel;
      cnt_inc <= next_cnt_inc;
      cnt_code <= next_cnt_code;
      cnt_pwr <= next_cnt_pwr;
      selector_alarm <= (next_cnt_sel != 5'h00);
      increment_confirm_alarm <= (next_cnt_inc != 5'h00);
      code_confirm_alarm <= (next_cnt_code != 5'h00);
      startup_alarm <= (next_cnt_pwr != 5'h00);
    end
  end

  // APB slave: one access cycle, read data prepared in the setup cycle
  logic [2:0] next_limit, wr_limit;
  logic [9:0] next_timeout, wr_timeout;
  logic [31:0] next_prdata;
  logic next_inc_mode, next_code_mode, next_pready, next_pslverr, wr_en, mapped;

  always_comb begin
    wr_en = psel & penable & pready & pwrite;
    mapped = (paddr == pss_pkg::OFS_CTRL) || (paddr == pss_pkg::OFS_TIMEOUT) ||
             (paddr == pss_pkg::OFS_STATUS);
    wr_limit = pwdata[pss_pkg::CTRL_LIMIT_LSB +: 3];
    wr_timeout = pwdata[9:0];
    next_limit = limit;
    next_inc_mode = inc_confirm_mode;
    next_code_mode = code_confirm_mode;
    next_timeout = timeout;
    if (wr_en && paddr == pss_pkg::OFS_CTRL) begin
      // Zero is not a usable limit, so it is raised to 1
      next_limit = (wr_limit < pss_pkg::LIMIT_MIN) ? pss_pkg::LIMIT_MIN : wr_limit;
      next_inc_mode = pwdata[pss_pkg::CTRL_INC_MODE];
      next_code_mode = pwdata[pss_pkg::CTRL_CODE_MODE];
    end
    if (wr_en && paddr == pss_pkg::OFS_TIMEOUT) begin
      if (wr_timeout < pss_pkg::TIMEOUT_MIN) begin
        next_timeout = pss_pkg::TIMEOUT_MIN;
      end else if (wr_timeout > pss_pkg::TIMEOUT_MAX) begin
        next_timeout = pss_pkg::TIMEOUT_MAX;
      end else begin
        next_timeout = wr_timeout;
      end
    end
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped;
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == pss_pkg::OFS_CTRL) begin
        next_prdata[pss_pkg::CTRL_LIMIT_LSB +: 3] = limit;
        next_prdata[pss_pkg::CTRL_INC_MODE] = inc_confirm_mode;
        next_prdata[pss_pkg::CTRL_CODE_MODE] = code_confirm_mode;
      end else if (paddr == pss_pkg::OFS_TIMEOUT) begin
        next_prdata[9:0] = timeout;
      end else if (paddr == pss_pkg::OFS_STATUS) begin
        next_prdata[pss_pkg::STAT_POS_LSB +: 3] = position;
        next_prdata[pss_pkg::STAT_PRE_LSB +: 3] = preselect;
        next_prdata[pss_pkg::STAT_INC_BUSY] = (state == pss_pkg::PSS_INC);
        next_prdata[pss_pkg::STAT_CODE_BUSY] = (state == pss_pkg::PSS_CODE);
        next_prdata[pss_pkg::STAT_SEL_ALARM] = selector_alarm;
        next_prdata[pss_pkg::STAT_INC_ALARM] = increment_confirm_alarm;
        next_prdata[pss_pkg::STAT_CODE_ALARM] = code_confirm_alarm;
        next_prdata[pss_pkg::STAT_PWR_ALARM] = startup_alarm;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit <= pss_pkg::LIMIT_RST;
      inc_confirm_mode <= 1'b0;
      code_confirm_mode <= 1'b0;
      timeout <= pss_pkg::TIMEOUT_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      limit <= next_limit;
      inc_confirm_mode <= next_inc_mode;
      code_confirm_mode <= next_code_mode;
      timeout <= next_timeout;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule : pss_top
`default_nettype wire

// File: tb/pss_assertions.sv
// Purpose: Port-level checks of the selector switch
// Assumes: TICK_CYCLES equals the bound instance's value
// Notes: Alarm length allows one cycle of slack each way
`default_nettype none
module pss_assertions #(
  parameter int unsigned TICK_CYCLES = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Step path
  input wire logic increment_in,
  input wire logic change_initiated,
  input wire logic [2:0] preselect,
  // Applied position
  input wire logic [2:0] position,
  input wire logic nv_write,
  input wire logic [2:0] nv_data,
  // Alarms
  input wire logic selector_alarm,
  input wire logic increment_confirm_alarm,
  input wire logic code_confirm_alarm
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [31:0] sel_cnt, next_sel_cnt;
  // Length of the selector alarm so far
  always_comb begin
    next_sel_cnt = selector_alarm ? sel_cnt + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_cnt <= 32'h0000_0000;
    end else begin
      sel_cnt <= next_sel_cnt;
    end
  end
  AST_NV_MIRROR: assert property (nv_data == position)
    else $error("stored copy differs from position");
  AST_NVW_APPLY: assert property (nv_write |-> position == preselect)
    else $error("store without applying preselect");
  AST_CHG_ONE: assert property (change_initiated |=> !change_initiated)
    else $error("change pulse too long");
  AST_CHG_EDGE: assert property (change_initiated |-> $past(increment_in, 2) && !$past(increment_in, 6))
    else $error("change pulse without step edge");
  AST_PRE_WRAP: assert property (change_initiated |-> preselect == 3'h1 ||
    preselect == 3'($past(preselect) + 3'h1))
    else $error("preselect did not advance");
  AST_SEL_LEN: assert property ($fell(selector_alarm) |->
    sel_cnt >= 29 * TICK_CYCLES - 1 && sel_cnt <= 30 * TICK_CYCLES + 1)
    else $error("selector alarm length wrong");
  AST_CODE_HOLD: assert property ($rose(code_confirm_alarm) |=> code_confirm_alarm [*8])
    else $error("code alarm too short");
  AST_INC_HOLD: assert property ($rose(increment_confirm_alarm) |=> increment_confirm_alarm [*8])
    else $error("step alarm too short");
endmodule : pss_assertions
bind pss_top pss_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_pss_assertions (
  .pclk, .presetn, .increment_in, .change_initiated, .preselect, .position, .nv_write, .nv_data,
  .selector_alarm, .increment_confirm_alarm, .code_confirm_alarm
);
`default_nettype wire

// File: tb/pss_partner.sv
// Purpose: Step source and non-volatile store beside the switch
// Assumes: Tick of 20 cycles, so 50 ms is 10 cycles
// Notes: Store has no reset, it must outlive one
`default_nettype none
module pss_partner (
  // Clock
  input wire logic pclk,
  // Store
  input wire logic nv_write,
  input wire logic [2:0] nv_data,
  output logic [2:0] nv_position,
  // Step source
  output logic increment_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial increment_in = 1'b0;
  always @(posedge pclk) begin
    if (nv_write) nv_position <= nv_data;
  end
  task automatic preload(input logic [2:0] v);
    nv_position <= v;
  endtask : preload
  // Long quiet gap keeps pulses well apart
  task automatic step();
    increment_in <= 1'b1;
    repeat (6) @(posedge pclk);
    increment_in <= 1'b0;
    repeat (14) @(posedge pclk);
  endtask : step
endmodule : pss_partner
`default_nettype wire

// File: tb/test_position_selector_switch.sv
// Purpose: Self-checking bench of the selector switch
// Assumes: Tick shortened to 20 cycles, time-out 3.0 s
// Notes: Step pulses come from the partner model
`default_nettype none
module test_position_selector_switch;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TC = 20;
  localparam int WT = 33 * TC; // Time-out plus sync slack
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic increment_confirm = 1'b0, code_confirm = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [2:0] code = 3'h0, nv_position, nv_data, position, preselect, cur, v, w;
  logic [1:0] powerup_mode = 2'h0;
  logic pready, pslverr, increment_in, nv_write, change_initiated;
  logic selector_alarm, increment_confirm_alarm, code_confirm_alarm, startup_alarm;
  int error_cnt = 0, checks_done = 0, chg = 0, cyc = 0, c0;
  always #5 pclk = ~pclk;
  pss_top #(.TICK_CYCLES(TC)) i_pss_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .increment_in, .increment_confirm, .code_bit0(code[0]), .code_bit1(code[1]), .code_bit2(code[2]),
    .code_confirm, .powerup_mode, .nv_position, .nv_write, .nv_data, .position, .preselect,
    .change_initiated, .selector_alarm, .increment_confirm_alarm, .code_confirm_alarm, .startup_alarm
  );
  pss_partner i_pss_partner (.pclk, .nv_write, .nv_data, .nv_position, .increment_in);
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (change_initiated === 1'b1) chg <= chg + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Called just after an edge; holds the request until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb
  task automatic wait_pos(input logic [2:0] e);
    for (int i = 0; i < WT && position !== e; i++) @(posedge pclk);
    check(position, e);
  endtask : wait_pos
  task automatic cf(input logic [1:0] s);
    {increment_confirm, code_confirm} <= s;
    repeat (5) @(posedge pclk);
    {increment_confirm, code_confirm} <= 2'b00;
    repeat (5) @(posedge pclk);
  endtask : cf
  task automatic rst();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : rst
  function automatic logic [2:0] nxt(input logic [2:0] p, input logic [2:0] l);
    return (p >= l) ? 3'h1 : p + 3'h1;
  endfunction : nxt
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    void'($urandom(32'he969_1ccb));
    cur = 3'($urandom_range(1, 7));
    i_pss_partner.preload(cur);
    rst();
    check(position, cur);
    check(startup_alarm, 1'b0);
    apb(1'b0, pss_pkg::OFS_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0007);
    apb(1'b0, pss_pkg::OFS_TIMEOUT, 32'h0000_0000);
    check(rd, 32'h0000_0032);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check(err, 1'b1);
    apb(1'b1, pss_pkg::OFS_TIMEOUT, 32'h0000_03FF);
    apb(1'b0, pss_pkg::OFS_TIMEOUT, 32'h0000_0000);
    check(rd, 32'h0000_0258);
    apb(1'b1, pss_pkg::OFS_TIMEOUT, 32'h0000_0001);
    apb(1'b0, pss_pkg::OFS_TIMEOUT, 32'h0000_0000);
    check(rd, 32'h0000_001E);
    apb(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0000);
    apb(1'b0, pss_pkg::OFS_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    // Limit 4 so that three steps never land back on the start position
    apb(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0004);
    $display("Test registers done");
    for (int k = 1; k <= 3; k++) begin
      c0 = chg;
      w = cur;
      repeat (k) begin
        i_pss_partner.step();
        w = nxt(w, 3'h4);
      end
      check(preselect, w);
      check(chg - c0, k);
      check(position, cur);
      wait_pos(w);
      cur = w;
    end
    $display("Test step path done");
    code <= 3'h5;
    repeat (20) @(posedge pclk);
    check(selector_alarm, 1'b1);
    code <= 3'h0;
    repeat (WT) @(posedge pclk);
    check(position, cur);
    apb(1'b1, pss_pkg::OFS_CTRL, 32'h0000_0007);
    v = 3'($urandom_range(4, 7));
    code <= v;
    repeat (4) @(posedge pclk);
    c0 = chg;
    i_pss_partner.step();
    check(chg, c0);
    wait_pos(v);
    check(preselect, v);
    $display("Test code path done");
    apb(1'b1, pss_pkg::OFS_CTRL, 32'h0000_001F);
    w = nxt(v, 3'h7);
    i_pss_partner.step();
    cf(2'b01);
    check(position, v);
    cf(2'b10);
    wait_pos(w);
    i_pss_partner.step();
    repeat (WT) @(posedge pclk);
    check(increment_confirm_alarm, 1'b1);
    check(position, w);
    check(preselect, w);
    code <= 3'(v % 7 + 1);
    repeat (WT) @(posedge pclk);
    check(code_confirm_alarm, 1'b1);
    check(position, w);
    code <= v;
    repeat (4) @(posedge pclk);
    cf(2'b10);
    check(position, w);
    cf(2'b01);
    wait_pos(v);
    repeat (WT) @(posedge pclk);
    $display("Test confirm modes done");
    for (int i = 0; i < 3; i++) begin
      powerup_mode <= (i == 2) ? 2'h0 : 2'h1;
      code <= (i == 1) ? 3'h6 : 3'h0;
      i_pss_partner.preload(3'h0);
      rst();
      check(position, (i == 1) ? 3'h6 : 3'h0);
      check(startup_alarm, i != 1);
    end
    $display("Test power-up done");
    stop_test();
  end
endmodule : test_position_selector_switch
`default_nettype wire
